// ---- shared/mil_defs.svh ----
// Purpose: named offsets, bit positions, reset values and timing counts of the interrupt logic
// Assumes: included by bare name from the package and design files
// Notes:   register offsets are word indexes; byte address is four times the index
`ifndef MIL_DEFS_SVH
`define MIL_DEFS_SVH

// ----------------------------------------------------------------------
// register indexes
// ----------------------------------------------------------------------
`define MIL_IDX_IRQ_CONTROL    8'h0b
`define MIL_IDX_PERIPH_FLAG    8'h0c
`define MIL_IDX_PERIPH_ENABLE  8'h8c
`define MIL_IDX_PRESCALE_CFG   8'h81
`define MIL_IDX_PIN_MASK       8'h96
`define MIL_IDX_CORE_STATUS    8'h10

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define MIL_BIT_PORT_FLAG      0
`define MIL_BIT_EXT_FLAG       1
`define MIL_BIT_T0_FLAG        2
`define MIL_BIT_PORT_EN        3
`define MIL_BIT_EXT_EN         4
`define MIL_BIT_T0_EN          5
`define MIL_BIT_PERIPH_GROUP   6
`define MIL_BIT_GLOBAL_EN      7
`define MIL_BIT_EDGE_POL       6
`define MIL_BIT_T1_WRAP        0
`define MIL_BIT_CMP            3
`define MIL_BIT_ADC_DONE       6
`define MIL_BIT_EE_WRITE       7

// ----------------------------------------------------------------------
// reset values, masks and constants
// ----------------------------------------------------------------------
`define MIL_RST_IRQ_CONTROL    8'h00
`define MIL_RST_PERIPH         8'h00
`define MIL_RST_PRESCALE_CFG   8'hff
`define MIL_RST_PIN_MASK       8'h00
`define MIL_PERIPH_MASK        8'hc9
`define MIL_IRQ_VECTOR         13'h0004
`define MIL_T0_TOP             8'hff
`define MIL_T0_ZERO            8'h00
`define MIL_Q_PER_TCY          4
`define MIL_DUMMY_TCY          2

`endif

// ---- shared/mil_pkg.sv ----
// Purpose: types shared by the interrupt logic modules
// Assumes: mil_defs.svh holds the register, field, reset and timing numbers
// Notes:   one-hot codes are written out
`include "mil_defs.svh"

package mil_pkg;

  typedef enum logic [3:0]
  {
    MIL_Q1 = 4'h1,
    MIL_Q2 = 4'h2,
    MIL_Q3 = 4'h4,
    MIL_Q4 = 4'h8
  } mil_qphase_t;

  typedef enum logic [1:0]
  {
    MIL_DISP_IDLE = 2'h1,
    MIL_DISP_WAIT = 2'h2
  } mil_disp_t;

endpackage

// ---- hw/mil_phase_gen.sv ----
// Purpose: four Q phases of the instruction cycle, one clock each
// Assumes: single clock, phases advance every clock
// Notes:   q1_pulse marks the first clock of each instruction cycle
`timescale 1ns/1ps

module mil_phase_gen
(
  input  wire logic               clk,      // system clock
  input  wire logic               arst_n,   // async reset, active low
  output mil_pkg::mil_qphase_t    q_phase,  // current phase, one-hot
  output logic                    q1_pulse  // high during Q1
);
  import mil_pkg::*;

  mil_qphase_t phase_reg;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      phase_reg <= MIL_Q1;
    else
    begin
      case (phase_reg)
        MIL_Q1:  phase_reg <= MIL_Q2;
        MIL_Q2:  phase_reg <= MIL_Q3;
        MIL_Q3:  phase_reg <= MIL_Q4;
        MIL_Q4:  phase_reg <= MIL_Q1;
        default: phase_reg <= MIL_Q1;
      endcase
    end
  end

  assign q_phase  = phase_reg;
  assign q1_pulse = (phase_reg == MIL_Q1);

endmodule

// ---- hw/mil_edge_det.sv ----
// Purpose: per-bit rising and falling edge detection
// Assumes: inputs synchronous to clk
// Notes:   no edge is reported until one sample has been taken after reset
`timescale 1ns/1ps

module mil_edge_det #(
  parameter int W = 1
)
(
  input  wire logic         clk,     // system clock
  input  wire logic         arst_n,  // async reset, active low
  input  wire logic [W-1:0] din,     // sampled inputs
  output logic      [W-1:0] rise,    // rising edge pulse per bit
  output logic      [W-1:0] fall     // falling edge pulse per bit
);
  logic [W-1:0] prev_reg;
  logic         primed_reg;

  // a pin already high at release must not read as a rise against the cleared sample
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      primed_reg <= 1'b0;
    else
      primed_reg <= 1'b1;
  end

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
          prev_reg[i] <= 1'b0;
        else
          prev_reg[i] <= din[i];
      end
      assign rise[i] = primed_reg & din[i] & ~prev_reg[i];
      assign fall[i] = primed_reg & ~din[i] & prev_reg[i];
    end
  endgenerate

endmodule

// ---- hw/mil_irq_top.sv ----
// Purpose: interrupt flags, enables and vectoring of a small 8-bit controller
// Assumes: Avalon-MM slave with waitrequest, byte addresses = 4 * register index
// Notes:   one clock per Q phase; four clocks make one instruction cycle
// How it works
// - external pin edge chosen by polarity bit
// - qualifying edge sets external pin flag
// - external pin enable masks its request
// - enabled pin event wakes; global enable decides branching
// - timer0 FF to 00 wrap sets flag
// - timer0 wrap enable gates its request
// - masked port pin change sets flag, enable gates
// - change during port read may be missed
// - conversion done sets flag, enable gates
// - pending request sampled once per cycle in Q1
// - external flag sets during Q4 through Q1
// - latency three to four instruction cycles
// - only the return address is saved
// - service clears global enable, pushes, vectors 0004h
// - global enable gates all; reset clears it
// - flags set regardless of any enable
// - return instruction sets global enable again
`timescale 1ns/1ps
`include "mil_defs.svh"

module mil_irq_top #(
  parameter int PINS = 6
)
(
  input  wire logic              clk,              // system clock, 20 MHz
  input  wire logic              arst_n,           // async reset, active low
  input  wire logic [9:0]        avs_address,      // byte address
  input  wire logic              avs_read,         // read strobe
  input  wire logic              avs_write,        // write strobe
  input  wire logic [31:0]       avs_writedata,    // write data
  input  wire logic [3:0]        avs_byteenable,   // byte lanes
  output logic      [31:0]       avs_readdata,     // read data
  output logic                   avs_waitrequest,  // stall
  input  wire logic              ext_irq_pin,      // external interrupt pin
  input  wire logic [7:0]        timer0_count,     // timer0 count value
  input  wire logic [PINS-1:0]   port_pins,        // port input levels
  input  wire logic              port_read,        // core reads the port
  input  wire logic              conv_done,        // a/d conversion done pulse
  input  wire logic              eeprom_done,      // eeprom write done pulse
  input  wire logic              cmp_change,       // comparator output change pulse
  input  wire logic              timer1_wrap,      // timer1 wrap pulse
  input  wire logic              ret_from_irq,     // return_from_irq_instr executes
  input  wire logic              sleeping,         // core is asleep
  output mil_pkg::mil_qphase_t   q_phase,          // current Q phase
  output logic                   irq_take,         // push pc and load vector
  output logic      [12:0]       irq_vector,       // vector address
  output logic                   wake              // wake core from sleep
);
  import mil_pkg::*;

  // ----------------------------------------------------------------------
  // registers and phase
  // ----------------------------------------------------------------------
  logic [7:0]      irq_control_reg;
  logic [7:0]      peripheral_flag_reg;
  logic [7:0]      peripheral_enable_reg;
  logic [7:0]      prescale_cfg_reg;
  logic [PINS-1:0] per_pin_change_mask_reg;
  logic [PINS-1:0] port_latch_reg;
  logic            ext_pend_reg;
  logic [7:0]      t0_prev_reg;
  logic            ack_reg;
  logic [31:0]     rdata_reg;
  mil_disp_t       disp_reg;
  logic [3:0]      wait_cnt_reg;
  logic            take_reg;
  logic            q1_pulse;
  logic            ext_rise;
  logic            ext_fall;

  mil_phase_gen u_phase
  (
    .clk      (clk),
    .arst_n   (arst_n),
    .q_phase  (q_phase),
    .q1_pulse (q1_pulse)
  );

  mil_edge_det #(.W(1)) u_ext_edge
  (
    .clk    (clk),
    .arst_n (arst_n),
    .din    (ext_irq_pin),
    .rise   (ext_rise),
    .fall   (ext_fall)
  );

  // ----------------------------------------------------------------------
  // bus decode: one wait cycle, then data stands while waitrequest is low
  // ----------------------------------------------------------------------
  logic [7:0] idx;
  logic       wr_go;
  logic       hit_ctrl;
  logic       hit_pflag;
  logic       hit_pen;
  logic       hit_cfg;
  logic       hit_mask;

  assign idx             = avs_address[9:2];
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign wr_go           = avs_write & ack_reg & avs_byteenable[0];
  assign hit_ctrl        = wr_go && (idx == `MIL_IDX_IRQ_CONTROL);
  assign hit_pflag       = wr_go && (idx == `MIL_IDX_PERIPH_FLAG);
  assign hit_pen         = wr_go && (idx == `MIL_IDX_PERIPH_ENABLE);
  assign hit_cfg         = wr_go && (idx == `MIL_IDX_PRESCALE_CFG);
  assign hit_mask        = wr_go && (idx == `MIL_IDX_PIN_MASK);
  assign avs_readdata    = rdata_reg;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ack_reg <= 1'b0;
    else
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata_reg <= 32'h0000_0000;
    else if (avs_read && !ack_reg)
    begin
      case (idx)
        `MIL_IDX_IRQ_CONTROL:   rdata_reg <= {24'h00_0000, irq_control_reg};
        `MIL_IDX_PERIPH_FLAG:   rdata_reg <= {24'h00_0000, peripheral_flag_reg};
        `MIL_IDX_PERIPH_ENABLE: rdata_reg <= {24'h00_0000, peripheral_enable_reg};
        `MIL_IDX_PRESCALE_CFG:  rdata_reg <= {24'h00_0000, prescale_cfg_reg};
        `MIL_IDX_PIN_MASK:      rdata_reg <= {{(32-PINS){1'b0}}, per_pin_change_mask_reg};
        `MIL_IDX_CORE_STATUS:   rdata_reg <= {30'h0000_0000, disp_reg == MIL_DISP_WAIT, wake};
        default:                rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      prescale_cfg_reg <= `MIL_RST_PRESCALE_CFG;
    else if (hit_cfg)
      prescale_cfg_reg <= avs_writedata[7:0];
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      per_pin_change_mask_reg <= PINS'(`MIL_RST_PIN_MASK);
    else if (hit_mask)
      per_pin_change_mask_reg <= avs_writedata[PINS-1:0];
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      peripheral_enable_reg <= `MIL_RST_PERIPH;
    else if (hit_pen)
      peripheral_enable_reg <= avs_writedata[7:0] & `MIL_PERIPH_MASK;
  end

  // ----------------------------------------------------------------------
  // event detection
  // ----------------------------------------------------------------------
  logic ext_hit;
  logic ext_apply;
  logic t0_wrap;
  logic port_change;

  assign ext_hit   = prescale_cfg_reg[`MIL_BIT_EDGE_POL] ? ext_rise : ext_fall;
  // an edge seen in Q2/Q3 is held so the flag only moves in Q4..Q1
  assign ext_apply = (ext_hit | ext_pend_reg) && (q_phase == MIL_Q4 || q_phase == MIL_Q1);
  assign t0_wrap   = (t0_prev_reg == `MIL_T0_TOP) && (timer0_count == `MIL_T0_ZERO);
  assign port_change = |((port_pins ^ port_latch_reg) & per_pin_change_mask_reg);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ext_pend_reg <= 1'b0;
    else if (ext_apply)
      ext_pend_reg <= 1'b0;
    else if (ext_hit)
      ext_pend_reg <= 1'b1;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      t0_prev_reg <= `MIL_T0_ZERO;
    else
      t0_prev_reg <= timer0_count;
  end

  // a port read refreshes the reference; a change racing the read is lost
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      port_latch_reg <= '0;
    else if (port_read)
      port_latch_reg <= port_pins;
  end

  // ----------------------------------------------------------------------
  // flag and enable registers; hardware set wins over software clear
  // ----------------------------------------------------------------------
  logic [7:0] ctrl_next;
  logic [7:0] pflag_next;

  always_comb
  begin
    ctrl_next = hit_ctrl ? avs_writedata[7:0] : irq_control_reg;
    if (ext_apply)
      ctrl_next[`MIL_BIT_EXT_FLAG] = 1'b1;
    if (t0_wrap)
      ctrl_next[`MIL_BIT_T0_FLAG] = 1'b1;
    if (port_change && !port_read)
      ctrl_next[`MIL_BIT_PORT_FLAG] = 1'b1;
    if (take_reg)
      ctrl_next[`MIL_BIT_GLOBAL_EN] = 1'b0;
    if (ret_from_irq)
      ctrl_next[`MIL_BIT_GLOBAL_EN] = 1'b1;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      irq_control_reg <= `MIL_RST_IRQ_CONTROL;
    else
      irq_control_reg <= ctrl_next;
  end

  always_comb
  begin
    pflag_next = hit_pflag ? (avs_writedata[7:0] & `MIL_PERIPH_MASK) : peripheral_flag_reg;
    if (conv_done)
      pflag_next[`MIL_BIT_ADC_DONE] = 1'b1;
    if (eeprom_done)
      pflag_next[`MIL_BIT_EE_WRITE] = 1'b1;
    if (cmp_change)
      pflag_next[`MIL_BIT_CMP] = 1'b1;
    if (timer1_wrap)
      pflag_next[`MIL_BIT_T1_WRAP] = 1'b1;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      peripheral_flag_reg <= `MIL_RST_PERIPH;
    else
      peripheral_flag_reg <= pflag_next;
  end

  // ----------------------------------------------------------------------
  // request gating
  // ----------------------------------------------------------------------
  logic ext_req;
  logic t0_req;
  logic port_req;
  logic periph_req;
  logic any_req;
  logic pending;

  assign ext_req    = irq_control_reg[`MIL_BIT_EXT_FLAG] & irq_control_reg[`MIL_BIT_EXT_EN];
  assign t0_req     = irq_control_reg[`MIL_BIT_T0_FLAG] & irq_control_reg[`MIL_BIT_T0_EN];
  assign port_req   = irq_control_reg[`MIL_BIT_PORT_FLAG] & irq_control_reg[`MIL_BIT_PORT_EN];
  assign periph_req = |(peripheral_flag_reg & peripheral_enable_reg)
                      & irq_control_reg[`MIL_BIT_PERIPH_GROUP];
  assign any_req    = ext_req | t0_req | port_req | periph_req;
  assign pending    = any_req & irq_control_reg[`MIL_BIT_GLOBAL_EN];
  // wake ignores the global enable; the core branches only if it is set
  assign wake       = sleeping & any_req;

  // ----------------------------------------------------------------------
  // dispatch: sample in Q1, two dummy cycles, then vector
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      disp_reg     <= MIL_DISP_IDLE;
      wait_cnt_reg <= 4'h0;
    end
    else
    begin
      case (disp_reg)
        MIL_DISP_IDLE:
        begin
          if (q1_pulse && pending && !sleeping)
          begin
            disp_reg     <= MIL_DISP_WAIT;
            wait_cnt_reg <= 4'((`MIL_DUMMY_TCY * `MIL_Q_PER_TCY) - 1);
          end
        end
        MIL_DISP_WAIT:
        begin
          if (wait_cnt_reg == 4'h0)
            disp_reg <= MIL_DISP_IDLE;
          else
            wait_cnt_reg <= wait_cnt_reg - 4'h1;
        end
        default: disp_reg <= MIL_DISP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      take_reg <= 1'b0;
    else
      take_reg <= (disp_reg == MIL_DISP_WAIT) && (wait_cnt_reg == 4'h1);
  end

  // the core pushes only its return pc on this pulse; no other state is saved
  assign irq_take   = take_reg;
  assign irq_vector = `MIL_IRQ_VECTOR;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_sample;
    disp_reg == MIL_DISP_IDLE && q1_pulse && pending && !sleeping;
  endsequence

  a_edge_sets_flag: assert property ((prescale_cfg_reg[`MIL_BIT_EDGE_POL] ? ext_rise : ext_fall)
    |-> ##[1:3] irq_control_reg[`MIL_BIT_EXT_FLAG]) else $error("edge did not set pin flag");
  a_wrong_edge_idle: assert property ((!ext_hit && !ext_pend_reg)
    |=> $stable(irq_control_reg[`MIL_BIT_EXT_FLAG]) || $past(hit_ctrl)) else $error("pin flag moved");
  a_ext_masked: assert property (!irq_control_reg[`MIL_BIT_EXT_EN] && !t0_req && !port_req && !periph_req
    |-> !pending) else $error("masked pin request pending");
  a_t0_wrap_flag: assert property ((timer0_count == `MIL_T0_TOP) ##1 (timer0_count == `MIL_T0_ZERO)
    |=> irq_control_reg[`MIL_BIT_T0_FLAG]) else $error("timer0 wrap flag missing");
  a_adc_flag_set: assert property (conv_done |=> peripheral_flag_reg[`MIL_BIT_ADC_DONE])
    else $error("conversion flag missing");
  a_take_latency: assert property (s_sample |=> ##7 irq_take) else $error("vector latency wrong");
  a_take_clears_ge: assert property (irq_take && !ret_from_irq |=> !irq_control_reg[`MIL_BIT_GLOBAL_EN])
    else $error("global enable kept after take");
  a_no_start_off: assert property (!irq_control_reg[`MIL_BIT_GLOBAL_EN] && disp_reg == MIL_DISP_IDLE
    |=> disp_reg == MIL_DISP_IDLE) else $error("dispatch without global enable");
  a_ret_sets_ge: assert property (ret_from_irq |=> irq_control_reg[`MIL_BIT_GLOBAL_EN])
    else $error("return did not set global enable");
  a_wake_enabled: assert property (sleeping && ext_req |-> wake) else $error("no wake");

endmodule

// ---- verif/mil_core_model.sv ----
// Purpose: behavioural core sequencer that sits on the far side of the interrupt logic
// Assumes: one clock; sleep and return requests are one-cycle pulses from the bench
// Notes:   leaves sleep wake_lag+1 clocks after wake, so a slow oscillator start is covered
`timescale 1ns/1ps

module mil_core_model
(
  input  wire logic       clk,           // system clock
  input  wire logic       arst_n,        // async reset, active low
  input  wire logic       irq_take,      // vector request from the block
  input  wire logic       wake,          // wake request from the block
  input  wire logic       sleep_req,     // bench asks the core to sleep
  input  wire logic       ret_req,       // bench asks for a return from irq
  input  wire logic [3:0] wake_lag,      // clocks from wake to running, less one
  output logic            sleeping,      // core asleep
  output logic            ret_from_irq,  // return instruction pulse
  output logic [7:0]      take_count     // vectors taken so far
);
  logic [3:0] lag_reg;

  // core stays asleep until the block asks, whatever the global enable says
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sleeping <= 1'b0;
      lag_reg  <= 4'h0;
    end
    else if (sleep_req)
      sleeping <= 1'b1;
    else if (sleeping && wake)
    begin
      if (lag_reg == wake_lag)
        sleeping <= 1'b0;
      lag_reg <= lag_reg + 4'h1;
    end
    else
      lag_reg <= 4'h0;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ret_from_irq <= 1'b0;
      take_count   <= 8'h00;
    end
    else
    begin
      ret_from_irq <= ret_req;
      take_count   <= take_count + {7'h00, irq_take};
    end
  end
endmodule

// ---- verif/testbench.sv ----
// Purpose: self-checking bench for the interrupt logic top
// Assumes: Avalon slave answers after one wait cycle; one clock per Q phase
// Notes:   every scenario is its own task and judges its own results
`timescale 1ns/1ps
`include "mil_defs.svh"

module testbench;
  import mil_pkg::*;

  localparam logic [9:0] A_CTL = {`MIL_IDX_IRQ_CONTROL, 2'b00};
  localparam logic [9:0] A_PFL = {`MIL_IDX_PERIPH_FLAG, 2'b00};
  localparam logic [9:0] A_PEN = {`MIL_IDX_PERIPH_ENABLE, 2'b00};
  localparam logic [9:0] A_CFG = {`MIL_IDX_PRESCALE_CFG, 2'b00};
  localparam logic [9:0] A_MSK = {`MIL_IDX_PIN_MASK, 2'b00};
  localparam logic [9:0] A_BAD = 10'h3fc;
  localparam logic [7:0] PBIT [4] = '{8'h40, 8'h80, 8'h08, 8'h01};

  logic        clk, arst_n, avs_read, avs_write, avs_waitrequest, ext_irq_pin, port_read;
  logic        conv_done, eeprom_done, cmp_change, timer1_wrap, ret_from_irq, sleeping;
  logic        irq_take, wake, sleep_req, ret_req;
  logic [3:0]  avs_byteenable, wake_lag;
  logic [9:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [7:0]  timer0_count, take_count;
  logic [5:0]  port_pins;
  logic [12:0] irq_vector;
  mil_qphase_t q_phase;
  int          fails, tests_run;

  mil_irq_top #(.PINS(6)) mil_irq_top_inst
  (
    .clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ext_irq_pin(ext_irq_pin),
    .timer0_count(timer0_count), .port_pins(port_pins), .port_read(port_read),
    .conv_done(conv_done), .eeprom_done(eeprom_done), .cmp_change(cmp_change),
    .timer1_wrap(timer1_wrap), .ret_from_irq(ret_from_irq), .sleeping(sleeping),
    .q_phase(q_phase), .irq_take(irq_take), .irq_vector(irq_vector), .wake(wake)
  );

  mil_core_model mil_core_model_inst
  (
    .clk(clk), .arst_n(arst_n), .irq_take(irq_take), .wake(wake), .sleep_req(sleep_req),
    .ret_req(ret_req), .wake_lag(wake_lag), .sleeping(sleeping), .ret_from_irq(ret_from_irq),
    .take_count(take_count)
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // waitrequest is judged where settled, just before the accepting edge
  task automatic bus(input logic is_wr, input logic [9:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= {24'h000000, d};
    avs_write     <= is_wr;
    avs_read      <= !is_wr;
    @(negedge clk);
    while (avs_waitrequest !== 1'b0 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 50)
    begin
      check("bus handshake", 32'h0, 32'h1);
      end_sim;
    end
    @(posedge clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string what, input logic [9:0] a, input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    check(what, {24'h000000, exp}, q);
  endtask

  task automatic pulse(input int k);
    @(posedge clk);
    case (k)
      0: conv_done <= 1'b1;
      1: eeprom_done <= 1'b1;
      2: cmp_change <= 1'b1;
      3: timer1_wrap <= 1'b1;
      4: port_read <= 1'b1;
      5: sleep_req <= 1'b1;
      default: ret_req <= 1'b1;
    endcase
    @(posedge clk);
    {conv_done, eeprom_done, cmp_change, timer1_wrap, port_read, sleep_req, ret_req} <= 7'h00;
  endtask

  task automatic wait_take(output int n);
    n = 0;
    @(negedge clk);
    while (irq_take !== 1'b1 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 40)
    begin
      check("irq_take handshake", 32'h1, 32'h0);
      end_sim;
    end
  endtask

  task automatic takes(input string what, input int span, input logic [7:0] exp);
    repeat (span) @(posedge clk);
    @(negedge clk);
    check(what, {24'h000000, exp}, {24'h000000, take_count});
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic s_reset;
    rd_chk("irq_control reset", A_CTL, 8'h00);
    rd_chk("periph flag reset", A_PFL, 8'h00);
    rd_chk("periph enable reset", A_PEN, 8'h00);
    wr(A_BAD, 8'hff);
    rd_chk("unmapped read", A_BAD, 8'h00);
    rd_chk("irq_control after unmapped write", A_CTL, 8'h00);
    avs_byteenable <= 4'he;
    wr(A_CTL, 8'h80);
    avs_byteenable <= 4'hf;
    rd_chk("write without lane 0", A_CTL, 8'h00);
  endtask

  task automatic s_ext;
    @(posedge clk);
    ext_irq_pin <= 1'b1;
    repeat (8) @(posedge clk);
    rd_chk("rising edge flag", A_CTL, 8'h02);
    wr(A_CTL, 8'h00);
    wr(A_CFG, 8'hbf);
    ext_irq_pin <= 1'b0;
    repeat (8) @(posedge clk);
    rd_chk("falling edge flag", A_CTL, 8'h02);
    wr(A_CTL, 8'h00);
    ext_irq_pin <= 1'b1;
    repeat (8) @(posedge clk);
    rd_chk("wrong edge ignored", A_CTL, 8'h00);
  endtask

  task automatic s_timer0;
    @(posedge clk);
    timer0_count <= 8'hfe;
    @(posedge clk);
    timer0_count <= 8'hff;
    @(posedge clk);
    timer0_count <= 8'h00;
    repeat (4) @(posedge clk);
    rd_chk("timer0 wrap flag", A_CTL, 8'h04);
    wr(A_CTL, 8'h00);
  endtask

  task automatic s_periph;
    logic [7:0] exp;
    exp = 8'h00;
    for (int k = 0; k < 4; k++)
    begin
      pulse(k);
      exp = exp | PBIT[k];
      rd_chk("periph flag set", A_PFL, exp);
    end
    wr(A_PFL, 8'h00);
    rd_chk("periph flag cleared", A_PFL, 8'h00);
  endtask

  task automatic s_port;
    pulse(4);
    wr(A_MSK, 8'h01);
    port_pins <= 6'h02;
    repeat (4) @(posedge clk);
    rd_chk("masked pin change", A_CTL, 8'h00);
    port_pins <= 6'h03;
    repeat (4) @(posedge clk);
    rd_chk("enabled pin change", A_CTL, 8'h01);
    pulse(4);
    wr(A_CTL, 8'h00);
    rd_chk("port flag cleared", A_CTL, 8'h00);
  endtask

  task automatic s_dispatch;
    int n;
    wr(A_CTL, 8'h24);
    takes("global enable clear blocks", 20, 8'h00);
    wr(A_CTL, 8'ha4);
    wait_take(n);
    check("latency in range", 32'h1, {31'h0, (n >= 8 && n <= 16)});
    check("vector", {19'h0, `MIL_IRQ_VECTOR}, {19'h0, irq_vector});
    check("take in Q1", {28'h0000000, MIL_Q1}, {28'h0000000, q_phase});
    rd_chk("global enable cleared", A_CTL, 8'h24);
    takes("one take", 0, 8'h01);
    wr(A_CTL, 8'h20);
    pulse(6);
    rd_chk("return sets global enable", A_CTL, 8'ha0);
    takes("no take after clear", 20, 8'h01);
  endtask

  task automatic s_masks;
    int n;
    wr(A_CTL, 8'h87);
    takes("flags without enables", 20, 8'h01);
    wr(A_CTL, 8'h00);
    wr(A_PEN, 8'h40);
    pulse(0);
    wr(A_CTL, 8'h80);
    takes("group enable clear", 20, 8'h01);
    wr(A_CTL, 8'hc0);
    wait_take(n);
    takes("peripheral dispatch", 1, 8'h02);
    wr(A_CTL, 8'h00);
    wr(A_PFL, 8'h00);
    wr(A_PEN, 8'h00);
  endtask

  task automatic s_sleep;
    int n;
    logic seen;
    seen = 1'b0;
    n = 0;
    wr(A_CTL, 8'h10);
    pulse(5);
    ext_irq_pin <= 1'b0;
    @(negedge clk);
    while (sleeping !== 1'b0 && n < 40)
    begin
      @(negedge clk);
      seen = seen | (wake === 1'b1);
      n++;
    end
    check("wake seen", 32'h1, {31'h0, seen});
    check("core awake", 32'h0, {31'h0, sleeping});
    takes("no vector with global enable clear", 20, 8'h02);
    wr(A_CTL, 8'h92);
    wait_take(n);
    takes("ext pin dispatch", 1, 8'h03);
    wr(A_CTL, 8'h00);
  endtask

  initial
  begin
    fails = 0;
    tests_run = 0;
    arst_n = 1'b0;
    {avs_read, avs_write, ext_irq_pin, port_read, conv_done, eeprom_done} = 6'h00;
    {cmp_change, timer1_wrap, sleep_req, ret_req} = 4'h0;
    avs_address = 10'h000;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hf;
    wake_lag = 4'h3;
    timer0_count = 8'h00;
    port_pins = 6'h00;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    s_reset;
    s_ext;
    s_timer0;
    s_periph;
    s_port;
    s_dispatch;
    s_masks;
    s_sleep;
    end_sim;
  end

  initial
  begin
    repeat (100000) @(posedge clk);
    check("run length", 32'h0, 32'h1);
    end_sim;
  end
endmodule
